/* hw/data_a_pkg.sv */
/*
 * Constants and carrier types for the port A pin steering block.
 * Assumes a 32-bit Avalon-MM register bus with word-aligned byte addresses.
 */
package data_a_pkg;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [3:0] OFS_DATA     = 4'h0;
   localparam logic [3:0] OFS_DIR      = 4'h4;
   localparam logic [3:0] OFS_LATCH    = 4'h8;
   localparam logic [3:0] OFS_ANALOG   = 4'hC;
   localparam logic [3:0] OFS_STEER    = 4'h0; // Upper bank, see below
   localparam logic       BANK_LOW     = 1'b0;
   localparam logic [1:0] IDX_STEER    = 2'h0;
   localparam logic [1:0] IDX_CONFIG   = 2'h1;

   // ************************************************************
   // Reset values and field layout
   // ************************************************************
   localparam logic [7:0] DIR_RST      = 8'hFF;
   localparam logic [7:0] LATCH_RST    = 8'h00;
   localparam logic [7:0] ANALOG_MASK  = 8'h2F;
   localparam logic [7:0] ANALOG_RST   = 8'h2F;
   localparam logic [7:0] STEER_RST    = 8'h00;
   localparam logic [2:0] CONFIG_RST   = 3'h0;
   localparam int         BIT_U3C      = 7;
   localparam int         BIT_U3B      = 6;
   localparam int         BIT_U2D      = 5;
   localparam int         BIT_U2C      = 4;
   localparam int         BIT_U2B      = 3;
   localparam int         BIT_U2MAIN   = 2;
   localparam int         BIT_U1C      = 1;
   localparam int         BIT_U1B      = 0;
   localparam int         CFG_XOUT     = 0;
   localparam int         CFG_SYSCLK_OUT   = 1;
   localparam int         CFG_XIN      = 2;

   // ************************************************************
   // Carrier types
   // ************************************************************
   typedef struct packed {
      logic       oe;
      logic       dat;
   } out_req_type;

   typedef struct packed {
      logic       read;
      logic       write;
      logic [5:0] address;
      logic [31:0] writedata;
   } bus_req_type;

   typedef struct packed {
      logic [7:0] seg_en;
      logic [7:0] seg_dat;
      logic       xout_dat;
      logic       sysclk_out_dat;
   } data_a_fn_type;

   // Steered capture/PWM requests, one entry per movable function
   typedef struct packed {
      out_req_type u3c;
      out_req_type u3b;
      out_req_type u2d;
      out_req_type u2c;
      out_req_type u2b;
      out_req_type u2main;
      out_req_type u1c;
      out_req_type u1b;
   } pwm_req_type;

   typedef struct packed {
      out_req_type [7:0] port_e;
      out_req_type [6:0] port_d;
      out_req_type       port_c1;
   } steered_type;

endpackage

/* hw/port_a_pin_steering.sv */
/*
 * Port A pin logic: direction, output latch, pin reads with analog masking,
 * output priority per pin, and steering of capture/PWM outputs between
 * alternate pins on ports C, D and E.
 * Assumes pins are synchronous to clk_sys and an Avalon-MM master that
 * holds its request until waitrequest is seen low.
 */
`timescale 1ns/1ps
module port_a_pin_steering (
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   input  wire logic [5:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic [7:0]            pad_a_in,
   output logic [7:0]                 pad_a_out,
   output logic [7:0]                 pad_a_oe_n,
   input  wire data_a_pkg::data_a_fn_type fn_req,
   input  wire data_a_pkg::pwm_req_type  pwm_req,
   input  wire logic [7:0]            pad_e_in,
   input  wire logic                  pad_c1_in,
   output data_a_pkg::steered_type     steered,
   output logic                       unit2_main_in
);

   // ************************************************************
   // Registers
   // ************************************************************
   logic [7:0]  dir_r;
   logic [7:0]  latch_r;
   logic [7:0]  analog_r;
   logic [7:0]  steer_r;
   logic [2:0]  config_r;
   logic [7:0]  pin_r;
   logic        ack_r;
   logic [31:0] rdata_nxt;
   logic        hit_lo;
   logic        hit_hi;
   logic        acc;
   logic        wr_go;
   logic        lane0;

   // Bank bit 5 splits port registers from steering/config
   assign acc    = (avs_read | avs_write) & ~ack_r;
   // Writes land on the answer edge, while the master still holds its request
   assign wr_go  = avs_write & ack_r & lane0;
   assign lane0  = avs_byteenable[0];
   assign hit_lo = (avs_address[5] == data_a_pkg::BANK_LOW) & (avs_address[1:0] == 2'h0)
                   & (avs_address[4] == 1'b0);
   assign hit_hi = (avs_address[5] != data_a_pkg::BANK_LOW) & (avs_address[1:0] == 2'h0)
                   & (avs_address[4] == 1'b0);

   // Pin sample: reads see the level one cycle old, a deliberate register stage
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pin_r <= 8'h00;
      end else begin
         pin_r <= pad_a_in;
      end
   end

   // Direction register
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dir_r <= data_a_pkg::DIR_RST;
      end else if (wr_go && hit_lo && avs_address[3:0] == data_a_pkg::OFS_DIR) begin
         dir_r <= avs_writedata[7:0];
      end
   end

   // Latch: data and latch offsets both land here
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         latch_r <= data_a_pkg::LATCH_RST;
      end else if (wr_go && hit_lo && (avs_address[3:0] == data_a_pkg::OFS_DATA
                                     || avs_address[3:0] == data_a_pkg::OFS_LATCH)) begin
         latch_r <= avs_writedata[7:0];
      end
   end

   // Analog select; unimplemented bits stay zero
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         analog_r <= data_a_pkg::ANALOG_RST;
      end else if (wr_go && hit_lo && avs_address[3:0] == data_a_pkg::OFS_ANALOG) begin
         analog_r <= avs_writedata[7:0] & data_a_pkg::ANALOG_MASK;
      end
   end

   // Steering and configuration-word image
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         steer_r  <= data_a_pkg::STEER_RST;
         config_r <= data_a_pkg::CONFIG_RST;
      end else if (wr_go && hit_hi) begin
         if (avs_address[3:2] == data_a_pkg::IDX_STEER) begin
            steer_r <= avs_writedata[7:0];
         end else if (avs_address[3:2] == data_a_pkg::IDX_CONFIG) begin
            config_r <= avs_writedata[2:0];
         end
      end
   end

   // ************************************************************
   // Bus answer: one wait cycle, then acknowledge
   // ************************************************************
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (hit_lo) begin
         case (avs_address[3:0])
            data_a_pkg::OFS_DATA:   rdata_nxt = {24'h00_0000, pin_r & ~analog_r};
            data_a_pkg::OFS_DIR:    rdata_nxt = {24'h00_0000, dir_r};
            data_a_pkg::OFS_LATCH:  rdata_nxt = {24'h00_0000, latch_r};
            data_a_pkg::OFS_ANALOG: rdata_nxt = {24'h00_0000, analog_r};
            default:               rdata_nxt = 32'h0000_0000;
         endcase
      end else if (hit_hi) begin
         case (avs_address[3:2])
            data_a_pkg::IDX_STEER:  rdata_nxt = {24'h00_0000, steer_r};
            data_a_pkg::IDX_CONFIG: rdata_nxt = {29'h0000_0000, config_r};
            default:               rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Ack register; unmapped reads return zero, writes are dropped
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ack_r           <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         ack_r           <= acc;
         // Own flop, so the bus sees no gate behind the register
         avs_waitrequest <= ~acc;
         if (acc && avs_read) begin
            avs_readdata <= rdata_nxt;
         end
      end
   end

   // ************************************************************
   // Port A drivers and priority
   // ************************************************************
   logic [7:0] own_oe;
   logic [7:0] own_dat;

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         // direction gates the port driver unless a segment or clock function owns the pin
         own_oe[i]  = ~dir_r[i];
         own_dat[i] = latch_r[i];
         if (fn_req.seg_en[i]) begin
            own_oe[i]  = 1'b1;
            own_dat[i] = fn_req.seg_dat[i];
         end
      end
      if (config_r[data_a_pkg::CFG_XOUT]) begin
         own_oe[6]  = 1'b1;
         own_dat[6] = fn_req.xout_dat;
      end else if (config_r[data_a_pkg::CFG_SYSCLK_OUT]) begin
         own_oe[6]  = 1'b1;
         own_dat[6] = fn_req.sysclk_out_dat;
      end
      if (config_r[data_a_pkg::CFG_XIN]) begin
         own_oe[7]  = 1'b0;
         own_dat[7] = 1'b0;
      end
   end

   // Registered pad drive; enable is active low
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pad_a_out  <= 8'h00;
         pad_a_oe_n <= 8'hFF;
      end else begin
         pad_a_out  <= own_dat;
         pad_a_oe_n <= ~own_oe;
      end
   end

   // ************************************************************
   // Capture/PWM steering
   // ************************************************************
   data_a_pkg::steered_type st_nxt;
   localparam data_a_pkg::out_req_type IDLE = '{oe: 1'b0, dat: 1'b0};

   // unselected pin sees an idle request; no direction register touched
   always_comb begin
      st_nxt = '0;
      if (steer_r[data_a_pkg::BIT_U3C]) st_nxt.port_d[3] = pwm_req.u3c;
      else                             st_nxt.port_e[3] = pwm_req.u3c;
      if (steer_r[data_a_pkg::BIT_U3B]) st_nxt.port_d[4] = pwm_req.u3b;
      else                             st_nxt.port_e[4] = pwm_req.u3b;
      if (steer_r[data_a_pkg::BIT_U2D]) st_nxt.port_d[0] = pwm_req.u2d;
      else                             st_nxt.port_e[0] = pwm_req.u2d;
      if (steer_r[data_a_pkg::BIT_U2C]) st_nxt.port_d[1] = pwm_req.u2c;
      else                             st_nxt.port_e[1] = pwm_req.u2c;
      if (steer_r[data_a_pkg::BIT_U2B]) st_nxt.port_d[2] = pwm_req.u2b;
      else                             st_nxt.port_e[2] = pwm_req.u2b;
      if (steer_r[data_a_pkg::BIT_U2MAIN]) st_nxt.port_e[7] = pwm_req.u2main;
      else                                st_nxt.port_c1   = pwm_req.u2main;
      if (steer_r[data_a_pkg::BIT_U1C]) st_nxt.port_d[5] = pwm_req.u1c;
      else                             st_nxt.port_e[5] = pwm_req.u1c;
      if (steer_r[data_a_pkg::BIT_U1B]) st_nxt.port_d[6] = pwm_req.u1b;
      else                             st_nxt.port_e[6] = pwm_req.u1b;
   end

   // Registered steering outputs and unit 2 input path
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         steered       <= '0;
         unit2_main_in <= 1'b0;
      end else begin
         steered       <= st_nxt;
         unit2_main_in <= steer_r[data_a_pkg::BIT_U2MAIN] ? pad_e_in[7] : pad_c1_in;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   dir_drive_a: assert property (@(posedge clk_sys) disable iff (srst)
      (dir_r == 8'hFF && fn_req.seg_en == 8'h00 && config_r == 3'h0)
      |=> pad_a_oe_n == 8'hFF) else $error("input pins driven");
   latch_drive_a: assert property (@(posedge clk_sys) disable iff (srst)
      (!dir_r[0] && !fn_req.seg_en[0]) |=> (!pad_a_oe_n[0] && pad_a_out[0] == $past(latch_r[0])))
      else $error("latch not driven");
   analog_read_a: assert property (@(posedge clk_sys) disable iff (srst)
      (acc && avs_read && hit_lo && avs_address[3:0] == data_a_pkg::OFS_DATA && analog_r[0])
      |=> avs_readdata[0] == 1'b0) else $error("analog pin read nonzero");
   latch_write_a: assert property (@(posedge clk_sys) disable iff (srst)
      (wr_go && hit_lo && avs_address[3:0] == data_a_pkg::OFS_LATCH)
      |=> latch_r == $past(avs_writedata[7:0])) else $error("latch write lost");
   seg_prio_a: assert property (@(posedge clk_sys) disable iff (srst)
      fn_req.seg_en[2] |=> (!pad_a_oe_n[2] && pad_a_out[2] == $past(fn_req.seg_dat[2])))
      else $error("segment lost priority");
   xout_prio_a: assert property (@(posedge clk_sys) disable iff (srst)
      config_r[data_a_pkg::CFG_XOUT] |=> pad_a_out[6] == $past(fn_req.xout_dat))
      else $error("pin 6 order wrong");
   xin_free_a: assert property (@(posedge clk_sys) disable iff (srst)
      config_r[data_a_pkg::CFG_XIN] |=> pad_a_oe_n[7]) else $error("pin 7 driven");
   steer_u3c_a: assert property (@(posedge clk_sys) disable iff (srst)
      steer_r[data_a_pkg::BIT_U3C] |=> steered.port_e[3] == IDLE)
      else $error("unit 3 C on both pins");
   steer_u2m_a: assert property (@(posedge clk_sys) disable iff (srst)
      !steer_r[data_a_pkg::BIT_U2MAIN] |=> steered.port_c1 == $past(pwm_req.u2main))
      else $error("unit 2 main not on C1");
   bus_ack_a: assert property (@(posedge clk_sys) disable iff (srst)
      (avs_read && avs_waitrequest) |=> !avs_waitrequest) else $error("bus answer late");

   // ************************************************************
   // Further checks: steering, priority, reset and bus timing
   // ************************************************************
   // Each movable output sits on one pin, the other pin idles
   steer_u3b_a: assert property (@(posedge clk_sys) disable iff (srst)
      !steer_r[data_a_pkg::BIT_U3B] |=> (steered.port_e[4] == $past(pwm_req.u3b)
      && steered.port_d[4] == IDLE)) else $error("unit 3 B misrouted");
   steer_u2d_a: assert property (@(posedge clk_sys) disable iff (srst)
      steer_r[data_a_pkg::BIT_U2D] |=> (steered.port_d[0] == $past(pwm_req.u2d)
      && steered.port_e[0] == IDLE)) else $error("unit 2 D misrouted");
   steer_u2c_a: assert property (@(posedge clk_sys) disable iff (srst)
      !steer_r[data_a_pkg::BIT_U2C] |=> (steered.port_e[1] == $past(pwm_req.u2c)
      && steered.port_d[1] == IDLE)) else $error("unit 2 C misrouted");
   steer_u2b_a: assert property (@(posedge clk_sys) disable iff (srst)
      steer_r[data_a_pkg::BIT_U2B] |=> (steered.port_d[2] == $past(pwm_req.u2b)
      && steered.port_e[2] == IDLE)) else $error("unit 2 B misrouted");
   steer_u1c_a: assert property (@(posedge clk_sys) disable iff (srst)
      steer_r[data_a_pkg::BIT_U1C] |=> (steered.port_d[5] == $past(pwm_req.u1c)
      && steered.port_e[5] == IDLE)) else $error("unit 1 C misrouted");
   steer_u1b_a: assert property (@(posedge clk_sys) disable iff (srst)
      !steer_r[data_a_pkg::BIT_U1B] |=> (steered.port_e[6] == $past(pwm_req.u1b)
      && steered.port_d[6] == IDLE)) else $error("unit 1 B misrouted");

   // Unit 2 main function uses the chosen pin both ways
   main_in_path_a: assert property (@(posedge clk_sys) disable iff (srst)
      steer_r[data_a_pkg::BIT_U2MAIN] |=> (unit2_main_in == $past(pad_e_in[7])
      && steered.port_c1 == IDLE)) else $error("unit 2 main path wrong");
   steer_dir_a: assert property (@(posedge clk_sys) disable iff (srst)
      (wr_go && hit_hi) |=> $stable(dir_r)) else $error("steering moved direction");

   // Analog select gates reads only; drivers and owners stay as they were
   analog_out_a: assert property (@(posedge clk_sys) disable iff (srst)
      (!dir_r[1] && !fn_req.seg_en[1] && analog_r[1])
      |=> (!pad_a_oe_n[1] && pad_a_out[1] == $past(latch_r[1])))
      else $error("analog pin not driven");
   analog_dir_a: assert property (@(posedge clk_sys) disable iff (srst)
      (dir_r[3] && analog_r[3] && !fn_req.seg_en[3]) |=> pad_a_oe_n[3])
      else $error("analog input driven");
   seg_analog_a: assert property (@(posedge clk_sys) disable iff (srst)
      (fn_req.seg_en[0] && analog_r[0])
      |=> (!pad_a_oe_n[0] && pad_a_out[0] == $past(fn_req.seg_dat[0])))
      else $error("segment lost on analog pin");

   // Lower-ranked owners of pins 6 and 7
   sysclk_out_prio_a: assert property (@(posedge clk_sys) disable iff (srst)
      (!config_r[data_a_pkg::CFG_XOUT] && config_r[data_a_pkg::CFG_SYSCLK_OUT])
      |=> (!pad_a_oe_n[6] && pad_a_out[6] == $past(fn_req.sysclk_out_dat)))
      else $error("clock out lost pin 6");
   seg_pin6_a: assert property (@(posedge clk_sys) disable iff (srst)
      (!config_r[data_a_pkg::CFG_XOUT] && !config_r[data_a_pkg::CFG_SYSCLK_OUT] && fn_req.seg_en[6])
      |=> (!pad_a_oe_n[6] && pad_a_out[6] == $past(fn_req.seg_dat[6])))
      else $error("segment lost pin 6");
   seg_pin7_a: assert property (@(posedge clk_sys) disable iff (srst)
      (!config_r[data_a_pkg::CFG_XIN] && fn_req.seg_en[7])
      |=> (!pad_a_oe_n[7] && pad_a_out[7] == $past(fn_req.seg_dat[7])))
      else $error("segment lost pin 7");
   latch_pin6_a: assert property (@(posedge clk_sys) disable iff (srst)
      (config_r == 3'h0 && !fn_req.seg_en[6] && !dir_r[6])
      |=> pad_a_out[6] == $past(latch_r[6])) else $error("latch lost pin 6");

   // Values right after reset
   analog_rst_a: assert property (@(posedge clk_sys) disable iff (srst)
      $past(srst) |-> analog_r == data_a_pkg::ANALOG_RST) else $error("analog reset wrong");
   dir_rst_a: assert property (@(posedge clk_sys) disable iff (srst)
      $past(srst) |-> (dir_r == data_a_pkg::DIR_RST && pad_a_oe_n == 8'hFF))
      else $error("direction reset wrong");
   steer_rst_a: assert property (@(posedge clk_sys) disable iff (srst)
      $past(srst) |-> (steer_r == data_a_pkg::STEER_RST && steered == '0))
      else $error("steering reset wrong");

   // Register accesses land on the answer edge
   dir_write_a: assert property (@(posedge clk_sys) disable iff (srst)
      (avs_write && !avs_waitrequest && avs_byteenable[0] && hit_lo
       && avs_address[3:0] == data_a_pkg::OFS_DIR) |=> dir_r == $past(avs_writedata[7:0]))
      else $error("direction write lost");
   data_write_a: assert property (@(posedge clk_sys) disable iff (srst)
      (wr_go && hit_lo && avs_address[3:0] == data_a_pkg::OFS_DATA)
      |=> latch_r == $past(avs_writedata[7:0])) else $error("data write lost");
   latch_read_a: assert property (@(posedge clk_sys) disable iff (srst)
      (acc && avs_read && hit_lo && avs_address[3:0] == data_a_pkg::OFS_LATCH)
      |=> avs_readdata == {24'h00_0000, $past(latch_r)}) else $error("latch readback wrong");
   pin_read_a: assert property (@(posedge clk_sys) disable iff (srst)
      (acc && avs_read && hit_lo && avs_address[3:0] == data_a_pkg::OFS_DATA)
      |=> avs_readdata[4] == $past(pin_r[4])) else $error("pin level not read");
   unmapped_read_a: assert property (@(posedge clk_sys) disable iff (srst)
      (acc && avs_read && avs_address[4]) |=> avs_readdata == 32'h0000_0000)
      else $error("unmapped read nonzero");
   answer_once_a: assert property (@(posedge clk_sys) disable iff (srst)
      !avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");

endmodule

/* sim/pin_world.sv */
/*
 * Pin side of port A and the steered capture/PWM pins.
 * Assumes the bench supplies the levels that outside parts drive.
 */
`timescale 1ns/1ps
module pin_world (
   input  wire logic [7:0]              pad_a_out,
   input  wire logic [7:0]              pad_a_oe_n,
   input  wire data_a_pkg::steered_type  steered,
   input  wire logic [7:0]              ext_a,
   input  wire logic [7:0]              ext_e,
   input  wire logic                    ext_c1,
   output logic [7:0]                   pad_a_in,
   output logic [7:0]                   pad_e_in,
   output logic                         pad_c1_in
);
   // ************************************************************
   // Wire levels
   // ************************************************************
   // driver or outside level
   // A driving device wins; otherwise the outside part sets the level
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pad_a_in[i] = pad_a_oe_n[i] ? ext_a[i] : pad_a_out[i];
         pad_e_in[i] = steered.port_e[i].oe ? steered.port_e[i].dat : ext_e[i];
      end
      pad_c1_in = steered.port_c1.oe ? steered.port_c1.dat : ext_c1;
   end
endmodule

/* sim/port_a_pin_steering_bench.sv */
/*
 * Self-checking bench: register accesses over Avalon-MM, pin checks.
 * Assumes the design answers each access with waitrequest low.
 */
`timescale 1ns/1ps
module port_a_pin_steering_bench;
   logic                       clk_sys, srst, avs_read, avs_write;
   logic [5:0]                 avs_address;
   logic [31:0]                avs_writedata, avs_readdata, q;
   logic [3:0]                 avs_byteenable;
   logic                       avs_waitrequest, pad_c1_in, ext_c1, unit2_main_in;
   logic [7:0]                 pad_a_in, pad_a_out, pad_a_oe_n, pad_e_in, ext_a, ext_e;
   logic [7:0]                 ep, sv;
   data_a_pkg::data_a_fn_type    fn_req;
   data_a_pkg::pwm_req_type     pwm_req;
   data_a_pkg::steered_type     steered;
   int                         error_cnt, compares;

   port_a_pin_steering uut (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pad_a_in(pad_a_in), .pad_a_out(pad_a_out),
      .pad_a_oe_n(pad_a_oe_n), .fn_req(fn_req), .pwm_req(pwm_req), .pad_e_in(pad_e_in),
      .pad_c1_in(pad_c1_in), .steered(steered), .unit2_main_in(unit2_main_in));
   pin_world pins (.pad_a_out(pad_a_out), .pad_a_oe_n(pad_a_oe_n), .steered(steered),
      .ext_a(ext_a), .ext_e(ext_e), .ext_c1(ext_c1), .pad_a_in(pad_a_in),
      .pad_e_in(pad_e_in), .pad_c1_in(pad_c1_in));

   // ************************************************************
   // Helpers
   // ************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic end_sim();
      if (error_cnt == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One access; request held until waitrequest is seen low at a rising edge
   task automatic bus(logic wr, logic [5:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      // Waitrequest is taken as it stood at each rising edge
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         n++;
         @(posedge clk_sys);
      end
      if (n >= 50) begin
         error_cnt++;
         end_sim();
      end else begin
         q = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask

   task automatic rd(logic [5:0] a, logic [7:0] e, string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, {24'h0, e}, q);
   endtask

   // Pads lag the registers by a cycle; three edges cover it
   task automatic pads(logic [7:0] oe_n, logic [7:0] o);
      repeat (3) @(posedge clk_sys);
      chk("oe_n", {24'h0, oe_n}, {24'h0, pad_a_oe_n});
      chk("out", {24'h0, o}, {24'h0, pad_a_out & ~pad_a_oe_n});
   endtask

   function automatic data_a_pkg::steered_type route(logic [7:0] s, data_a_pkg::pwm_req_type p);
      data_a_pkg::steered_type r;
      r = '0;
      if (s[7]) r.port_d[3] = p.u3c; else r.port_e[3] = p.u3c;
      if (s[6]) r.port_d[4] = p.u3b; else r.port_e[4] = p.u3b;
      if (s[5]) r.port_d[0] = p.u2d; else r.port_e[0] = p.u2d;
      if (s[4]) r.port_d[1] = p.u2c; else r.port_e[1] = p.u2c;
      if (s[3]) r.port_d[2] = p.u2b; else r.port_e[2] = p.u2b;
      if (s[2]) r.port_e[7] = p.u2main; else r.port_c1 = p.u2main;
      if (s[1]) r.port_d[5] = p.u1c; else r.port_e[5] = p.u1c;
      if (s[0]) r.port_d[6] = p.u1b; else r.port_e[6] = p.u1b;
      return r;
   endfunction

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      error_cnt = 0;
      compares = 0;
      srst = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hF;
      fn_req = '0;
      pwm_req = '0;
      ext_a = 8'h3C;
      ext_e = 8'h80;
      ext_c1 = 1'b0;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      // Reset values, unmapped place
      rd(6'h04, 8'hFF, "dir");
      rd(6'h08, 8'h00, "latch");
      rd(6'h0C, 8'h2F, "analog");
      rd(6'h20, 8'h00, "steer");
      rd(6'h10, 8'h00, "unmapped");
      pads(8'hFF, 8'h00);
      // Latch to pins, analog masking of reads
      bus(1'b1, 6'h08, 32'hA5);
      bus(1'b1, 6'h04, 32'h0F);
      pads(8'h0F, 8'hA0);
      rd(6'h00, 8'h80, "data masked");
      bus(1'b1, 6'h0C, 32'hFF);
      rd(6'h0C, 8'h2F, "analog bits");
      bus(1'b1, 6'h0C, 32'h00);
      rd(6'h00, 8'hAC, "data pins");
      rd(6'h08, 8'hA5, "latch read");
      bus(1'b1, 6'h00, 32'h3C);
      rd(6'h08, 8'h3C, "data to latch");
      bus(1'b1, 6'h24, 32'h0); // config image
      avs_byteenable <= 4'hE;
      bus(1'b1, 6'h08, 32'h77);
      avs_byteenable <= 4'hF;
      rd(6'h08, 8'h3C, "byteenable");
      bus(1'b1, 6'h14, 32'hFF);
      rd(6'h14, 8'h00, "unmapped wr");
      // Output priority, analog set on pins 0-3 and 5
      bus(1'b1, 6'h0C, 32'h2F);
      bus(1'b1, 6'h04, 32'h00);
      bus(1'b1, 6'h08, 32'h65);
      pads(8'h00, 8'h65);
      for (int p = 0; p < 2; p++) begin
         fn_req <= '{seg_en: 8'hFF, seg_dat: 8'h9A, xout_dat: p[0], sysclk_out_dat: !p[0]};
         for (int c = 0; c < 8; c++) begin
            bus(1'b1, 6'h24, 32'(c));
            ep = {1'b1, (c[0] ? p[0] : c[1] ? !p[0] : 1'b0), 6'h1A};
            pads({c[2], 7'h0}, ep & ~{c[2], 7'h0});
         end
      end
      fn_req <= '0;
      bus(1'b1, 6'h24, 32'h0);
      // Steering, single bits and all bits
      for (int k = 0; k < 10; k++) begin
         sv = (k == 0) ? 8'h00 : (k == 9) ? 8'hFF : 8'(1 << (k - 1));
         pwm_req <= k[0] ? 16'hDA4F : 16'h67D9;
         bus(1'b1, 6'h20, {24'h0, sv});
         repeat (3) @(posedge clk_sys);
         chk("steered", 32'(route(sv, pwm_req)), 32'(steered));
         chk("main in", {31'h0, sv[2]}, {31'h0, unit2_main_in});
         rd(6'h20, sv, "steer read");
      end
      rd(6'h04, 8'h00, "dir kept");
      pads(8'h00, 8'h65);
      bus(1'b1, 6'h04, 32'h2F);
      pads(8'h2F, 8'h40);
      end_sim();
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      end_sim();
   end
endmodule
